// file: logic/dbs_sram.sv
// ddr four-word burst sram device core with its write buffer
`timescale 1ns/100ps

// synchronous fifo with valid and ready on both sides
module dbs_fifo #(
	parameter int W = 8, // word width
	parameter int D = 8  // depth in words
) (
	input  wire logic         clk,       // system clock
	input  wire logic         rst_n,     // async reset, low
	input  wire logic         in_valid,  // word offered
	output logic              in_ready,  // room for a word
	input  wire logic [W-1:0] in_data,   // word in
	output logic              out_valid, // word available
	input  wire logic         out_ready, // sink takes word
	output logic [W-1:0]      out_data   // word out
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem [0:D-1]; // storage
	logic [PW:0]  wp_r;        // write pointer with wrap bit
	logic [PW:0]  rp_r;        // read pointer with wrap bit
	logic         full;        // no room left
	logic         empty;       // nothing stored

	assign full      = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
	assign empty     = (wp_r == rp_r);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[PW-1:0]];

	// storage write
	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wp_r[PW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full) begin
				wp_r <= wp_r + (PW+1)'(1);
			end
			if (out_ready && !empty) begin
				rp_r <= rp_r + (PW+1)'(1);
			end
		end
	end
endmodule

// device top
module dbs_sram
	import dbs_pkg::*;
(
	input  wire logic                     clk,        // system clock
	input  wire logic                     rst_n,      // async reset, low
	input  wire logic                     in_clk_p,   // input clock
	input  wire logic                     in_clk_n,   // inverted input clk
	input  wire logic                     out_clk_p,  // output clock
	input  wire logic                     out_clk_n,  // inverted out clk
	input  wire logic                     rd_sel_n,   // read select, low
	input  wire logic                     wr_sel_n,   // write select, low
	input  wire logic [dbs_pkg::ADDR_W-1:0] addr_in,  // burst address
	input  wire logic [dbs_pkg::DQ_W-1:0] d_in,       // write data
	input  wire logic                     byte_wr_n0, // lane 0 enable, low
	input  wire logic                     byte_wr_n1, // lane 1 enable, low
	input  wire logic                     byte_wr_n2, // lane 2 enable, low
	input  wire logic                     byte_wr_n3, // lane 3 enable, low
	input  wire logic                     nib_wr_n0,  // x8 nibble 0, low
	input  wire logic                     nib_wr_n1,  // x8 nibble 1, low
	output logic [dbs_pkg::DQ_W-1:0]      q_out,      // read data
	output logic                          q_oe,       // read data driven
	output logic                          echo_clk_p, // echo clock
	output logic                          echo_clk_n  // inverted echo clk
);
	import dbs_pkg::*;

	// bits of the word that a lane enable covers
	function automatic logic [DQ_W-1:0] bit_mask(input logic [LANES-1:0] en);
		logic [DQ_W-1:0] m;
		m = '0;
		for (int b = 0; b < CFG_W; b++) begin
			m[b] = (CFG_W == 8) ? en[b / 4] : en[b / 9];
		end
		return m;
	endfunction

	dbs_pins_s       raw;       // pins gathered
	dbs_pins_s       s1_r;      // first sync stage
	dbs_pins_s       s2_r;      // second sync stage
	dbs_pins_s       s3_r;      // previous synced sample
	logic            kp_rise;   // K rising edge seen
	logic            kn_rise;   // K# rising edge seen
	logic            kmode;     // output clocks tied high
	logic            ref_p;     // output reference, odd beats
	logic            ref_n;     // output reference, even beats
	logic            wr_start;  // write burst starts
	logic            rd_start;  // read burst requested
	logic            wr_ign_r;  // write started on last K
	logic            rd_ign_r;  // read started on last K
	logic            wr_busy_r; // write burst in progress
	logic [1:0]      wr_cnt_r;  // write beat index
	logic [ADDR_W-1:0] wbase_r; // write base address
	logic [DQ_W-1:0] h0_d_r;    // held beat 0 data
	logic [LANES-1:0] h0_e_r;   // held beat 0 lanes
	logic            h1_v_r;    // beat 1 waits for push
	logic [DQ_W-1:0] h1_d_r;    // held beat 1 data
	logic [LANES-1:0] h1_e_r;   // held beat 1 lanes
	dbs_beat_s       push;      // beat offered to buffer
	logic            push_v;    // push valid
	logic            push_rdy;  // buffer has room
	dbs_beat_s       drain;     // beat leaving buffer
	logic            drain_v;   // drain valid
	logic            drain_rdy; // array free to write
	logic [DQ_W-1:0] mem [0:MEM_D-1]; // storage array
	dbs_rd_st_e      rd_st_r;   // read machine state
	logic [1:0]      rd_cnt_r;  // next read beat index
	logic            rd_pend_r; // read waiting to launch
	logic [ADDR_W-1:0] rd_pbase_r; // waiting read base
	logic [ADDR_W-1:0] rd_base_r;  // active read base
	logic            launch;    // a read word goes out
	logic [1:0]      beat;      // index of word going out
	logic [ADDR_W-1:0] lbase;   // base of word going out

	assign raw = '{kp: in_clk_p, kn: in_clk_n, cp: out_clk_p,
		cn: out_clk_n, rd_n: rd_sel_n, wr_n: wr_sel_n, addr: addr_in,
		d: d_in,
		en: (CFG_W == 8) ? {2'h0, ~nib_wr_n1, ~nib_wr_n0}
			: (CFG_W == 18) ? {2'h0, ~byte_wr_n1, ~byte_wr_n0}
			: {~byte_wr_n3, ~byte_wr_n2, ~byte_wr_n1, ~byte_wr_n0}};

	// two-stage synchroniser on every pin, plus edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign kp_rise  = s2_r.kp && !s3_r.kp;
	assign kn_rise  = s2_r.kn && !s3_r.kn;
	assign kmode    = s2_r.cp && s2_r.cn;
	assign ref_p    = kmode ? kp_rise : (s2_r.cp && !s3_r.cp);
	assign ref_n    = kmode ? kn_rise : (s2_r.cn && !s3_r.cn);
	assign wr_start = kp_rise && !s2_r.wr_n && !wr_ign_r;
	assign rd_start = kp_rise && !s2_r.rd_n && !rd_ign_r;

	// consecutive-edge request guards, moved only on K
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ign_r <= 1'b0;
			rd_ign_r <= 1'b0;
		end else if (kp_rise) begin
			wr_ign_r <= wr_start;
			rd_ign_r <= rd_start;
		end
	end

	// write machine: beats on K, K#, K, K#
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy_r <= 1'b0;
			wr_cnt_r  <= 2'h0;
			wbase_r   <= '0;
			h0_d_r    <= '0;
			h0_e_r    <= '0;
			h1_v_r    <= 1'b0;
			h1_d_r    <= '0;
			h1_e_r    <= '0;
		end else begin
			h1_v_r <= 1'b0;
			if (wr_start) begin
				// beat 0 held until the address arrives
				wr_busy_r <= 1'b1;
				wr_cnt_r  <= 2'h0;
				h0_d_r    <= s2_r.d;
				h0_e_r    <= s2_r.en;
			end else if (kp_rise && wr_busy_r && wr_cnt_r == 2'h1) begin
				wr_cnt_r <= 2'h2;
			end else if (kn_rise && wr_busy_r) begin
				if (wr_cnt_r == 2'h0) begin
					wbase_r  <= s2_r.addr;
					h1_v_r   <= 1'b1;
					h1_d_r   <= s2_r.d;
					h1_e_r   <= s2_r.en;
					wr_cnt_r <= 2'h1;
				end else if (wr_cnt_r == 2'h2) begin
					wr_busy_r <= 1'b0;
					wr_cnt_r  <= BEAT_LAST;
				end
			end
		end
	end

	// beat offered to the write buffer, one per cycle
	always_comb begin
		push_v = 1'b0;
		push   = '0;
		if (kn_rise && wr_busy_r && wr_cnt_r == 2'h0) begin
			push_v = 1'b1;
			push   = '{waddr: {s2_r.addr, 2'h0}, data: h0_d_r, en: h0_e_r};
		end else if (h1_v_r) begin
			push_v = 1'b1;
			push   = '{waddr: {wbase_r, 2'h1}, data: h1_d_r, en: h1_e_r};
		end else if (kp_rise && wr_busy_r && wr_cnt_r == 2'h1) begin
			push_v = 1'b1;
			push   = '{waddr: {wbase_r, 2'h2}, data: s2_r.d, en: s2_r.en};
		end else if (kn_rise && wr_busy_r && wr_cnt_r == 2'h2) begin
			push_v = 1'b1;
			push   = '{waddr: {wbase_r, BEAT_LAST}, data: s2_r.d,
				en: s2_r.en};
		end
	end

	dbs_fifo #(
		.W(BEAT_W),
		.D(FIFO_D)
	) u_wbuf (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_valid (push_v),
		.in_ready (push_rdy),
		.in_data  (push),
		.out_valid(drain_v),
		.out_ready(drain_rdy),
		.out_data (drain)
	);

	// array port is shared: a read launch stalls the drain
	assign drain_rdy = !launch;

	// masked array write
	always_ff @(posedge clk) begin
		if (drain_v && drain_rdy) begin
			mem[drain.waddr] <= (mem[drain.waddr] & ~bit_mask(drain.en))
				| (drain.data & bit_mask(drain.en));
		end
	end

	// read launch decode
	always_comb begin
		launch = 1'b0;
		beat   = rd_cnt_r;
		lbase  = rd_base_r;
		if (ref_n && rd_st_r == DBS_RD_IDLE && rd_pend_r) begin
			launch = 1'b1;
			beat   = 2'h0;
			lbase  = rd_pbase_r;
		end else if (rd_st_r == DBS_RD_BURST) begin
			launch = ref_n ? !rd_cnt_r[0] : (ref_p && rd_cnt_r[0]);
		end
	end

	// read request capture; a new request wins over the launch clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_r  <= 1'b0;
			rd_pbase_r <= '0;
		end else if (rd_start) begin
			rd_pend_r  <= 1'b1;
			rd_pbase_r <= s2_r.addr;
		end else if (launch && rd_st_r == DBS_RD_IDLE) begin
			rd_pend_r <= 1'b0;
		end
	end

	// read machine: words on C#, C, C#, C
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_st_r   <= DBS_RD_IDLE;
			rd_cnt_r  <= 2'h0;
			rd_base_r <= '0;
		end else if (launch) begin
			rd_base_r <= lbase;
			rd_cnt_r  <= beat + 2'h1;
			rd_st_r   <= (beat == BEAT_LAST) ? DBS_RD_IDLE : DBS_RD_BURST;
		end
	end

	// output data, enable and echo clocks, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_out      <= '0;
			q_oe       <= 1'b0;
			echo_clk_p <= 1'b0;
			echo_clk_n <= 1'b0;
		end else begin
			echo_clk_p <= kmode ? s2_r.kp : s2_r.cp;
			echo_clk_n <= kmode ? s2_r.kn : s2_r.cn;
			if (launch) begin
				q_out <= mem[{lbase, beat}] & bit_mask({LANES{1'b1}});
				q_oe  <= 1'b1;
			end else if (ref_p || ref_n) begin
				q_oe <= 1'b0;
			end
		end
	end

	// checks
	sequence s_rd_last;
		launch && beat == BEAT_LAST;
	endsequence
	sequence s_wr_go;
		wr_start;
	endsequence
	property p_wr_start;
		@(posedge clk) disable iff (!rst_n)
		s_wr_go |=> wr_busy_r && wr_cnt_r == 2'h0 && wr_ign_r;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write burst did not start");
	property p_wr_addr;
		@(posedge clk) disable iff (!rst_n)
		kn_rise && wr_busy_r && wr_cnt_r == 2'h0
			|=> wbase_r == $past(s2_r.addr) ##1 h1_v_r == 1'b0;
	endproperty
	a_wr_addr: assert property (p_wr_addr)
		else $error("write address not taken on K#");
	property p_wr_end;
		@(posedge clk) disable iff (!rst_n)
		kn_rise && wr_busy_r && wr_cnt_r == 2'h2 |=> !wr_busy_r;
	endproperty
	a_wr_end: assert property (p_wr_end)
		else $error("write burst did not end after four");
	property p_no_b2b;
		@(posedge clk) disable iff (!rst_n)
		kp_rise && wr_ign_r |=> wr_busy_r && wr_cnt_r == 2'h2;
	endproperty
	a_no_b2b: assert property (p_no_b2b)
		else $error("second write on consecutive K accepted");
	property p_no_ovf;
		@(posedge clk) disable iff (!rst_n)
		push_v |-> push_rdy;
	endproperty
	a_no_ovf: assert property (p_no_ovf)
		else $error("write beat lost to a full buffer");
	property p_rd_step;
		@(posedge clk) disable iff (!rst_n)
		launch && beat != BEAT_LAST |=> rd_cnt_r == $past(beat) + 2'h1
			&& rd_st_r == DBS_RD_BURST;
	endproperty
	a_rd_step: assert property (p_rd_step)
		else $error("read burst index did not step");
	property p_rd_end;
		@(posedge clk) disable iff (!rst_n)
		s_rd_last |=> rd_st_r == DBS_RD_IDLE && q_oe;
	endproperty
	a_rd_end: assert property (p_rd_end)
		else $error("read burst did not close");
	property p_oe_cause;
		@(posedge clk) disable iff (!rst_n)
		$rose(q_oe) |-> $past(launch && beat == 2'h0);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("outputs driven without a read");
	property p_first_on_n;
		@(posedge clk) disable iff (!rst_n)
		launch && beat == 2'h0 |-> ref_n;
	endproperty
	a_first_on_n: assert property (p_first_on_n)
		else $error("first read word not on C#");
	property p_mask;
		@(posedge clk) disable iff (!rst_n)
		drain_v && drain_rdy && !drain.en[0]
			|=> mem[$past(drain.waddr)][0] == $past(mem[drain.waddr][0]);
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked lane was written");
	property p_echo;
		@(posedge clk) disable iff (!rst_n)
		ref_p |=> echo_clk_p;
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo clock missed a reference edge");
endmodule

// file: logic/dbs_pkg.sv
// shared constants and types of the ddr burst sram device
package dbs_pkg;
	localparam int CFG_W   = 18;           // device data width: 8, 18 or 36
	localparam int DQ_W    = 36;           // widest data bus
	localparam int ADDR_W  = 18;           // external burst address width
	localparam int WADDR_W = ADDR_W + 2;   // word address incl. burst bits
	localparam int MEM_D   = 1 << WADDR_W; // words in the array
	localparam int BURST_N = 4;            // words per burst
	localparam int LANES   = 4;            // write mask lanes
	localparam int FIFO_D  = 8;            // write buffer depth
	localparam logic [1:0] BEAT_LAST = 2'h3; // last beat index
	// read machine states
	typedef enum logic {
		DBS_RD_IDLE  = 1'b0,
		DBS_RD_BURST = 1'b1
	} dbs_rd_st_e;
	// raw pins as they arrive from the controller
	typedef struct packed {
		logic              kp;    // input clock
		logic              kn;    // inverted input clock
		logic              cp;    // output clock
		logic              cn;    // inverted output clock
		logic              rd_n;  // read select
		logic              wr_n;  // write select
		logic [ADDR_W-1:0] addr;  // address
		logic [DQ_W-1:0]   d;     // write data
		logic [LANES-1:0]  en;    // lane enables, active high
	} dbs_pins_s;
	// one write beat bound for the array
	typedef struct packed {
		logic [WADDR_W-1:0] waddr; // word address
		logic [DQ_W-1:0]    data;  // beat data
		logic [LANES-1:0]   en;    // lanes to write
	} dbs_beat_s;
	localparam int BEAT_W = $bits(dbs_beat_s);
endpackage

// file: bench/dbs_ctl_model.sv
// controller model: link clocks, strobes, address and gated write data
`timescale 1ns/100ps
module dbs_ctl_model
	import dbs_pkg::*;
(
	output logic                     in_clk_p,  // input clock
	output logic                     in_clk_n,  // inverted input clock
	output logic                     out_clk_p, // output clock
	output logic                     out_clk_n, // inverted output clock
	output logic                     rd_sel_n,  // read select
	output logic                     wr_sel_n,  // write select
	output logic [dbs_pkg::ADDR_W-1:0] addr_in, // burst address
	output logic [dbs_pkg::DQ_W-1:0] d_in,      // write data
	output logic [dbs_pkg::LANES-1:0] wr_n,     // lane enables, low
	output logic [1:0]               nib_n      // nibble enables, low
);
	logic kmode = 1'b0; // output clocks tied high
	logic stop  = 1'b0; // input clocks parked low, output clocks too unless kmode
	// idle pins from time zero
	initial begin
		in_clk_p = 1'b0;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		addr_in  = '0;
		d_in     = '0;
		wr_n     = '1;
		nib_n    = '1;
	end
	// free-running input clock, 160 ns period
	always #80 if (!stop) in_clk_p = ~in_clk_p;
	assign in_clk_n  = stop ? in_clk_p : ~in_clk_p;
	assign out_clk_p = kmode | in_clk_p;
	assign out_clk_n = kmode | in_clk_n;
	// one burst slot: pins change mid-phase, held over the next edge
	task automatic slot(input logic rd, input logic wr, input logic dup,
		input logic [ADDR_W-1:0] ar, input logic [ADDR_W-1:0] aw,
		input logic [4*DQ_W-1:0] dat, input logic [7:0] en);
		for (int i = 0; i < 4; i++) begin
			if (i[0]) @(posedge in_clk_p);
			else @(negedge in_clk_p);
			#40;
			if (i == 0) begin // strobes for the starting edge
				rd_sel_n = ~rd;
				wr_sel_n = ~wr;
			end
			if (i == 2) begin // dup breaks the spacing on purpose
				rd_sel_n = ~(rd & dup);
				wr_sel_n = ~(wr & dup);
			end
			if (i == 3) begin // strobes back high before the next K
				rd_sel_n = 1'b1;
				wr_sel_n = 1'b1;
			end
			addr_in = (i == 0) ? ar : (i == 1) ? aw : ~aw;
			d_in    = dat[i*DQ_W +: DQ_W];
			wr_n    = {2'b11, ~en[2*i +: 2]};
			nib_n   = ~en[2*i +: 2];
		end
		// data hold over: drive the inverse, not the last beat
		@(posedge in_clk_p);
		#40;
		d_in    = ~d_in;
		addr_in = ~addr_in;
	endtask
	// clock stop: input clocks parked low for n half periods, output clocks too unless kmode holds them high
	task automatic halt(input int n);
		@(negedge in_clk_p);
		#40;
		stop = 1'b1;
		#(80 * n);
		stop = 1'b0;
	endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench of the ddr burst sram device
`timescale 1ns/100ps
module tb_top;
	import dbs_pkg::*;
	typedef struct packed {
		logic              rd;   // read request
		logic              wr;   // write request
		logic              dup;  // strobe repeated
		logic [ADDR_W-1:0] ar;   // read address
		logic [ADDR_W-1:0] aw;   // write address
		logic [7:0]        pat;  // data pattern
		logic [7:0]        en;   // lanes per beat
	} dbs_row_s;
	logic              clk = 1'b0;     // system clock
	logic              rst_n = 1'b0;   // reset, low
	logic              kp, kn, cp, cn; // link clocks
	logic              rdn, wrn;       // selects
	logic [ADDR_W-1:0] addr;           // address pins
	logic [DQ_W-1:0]   d, q;           // data pins
	logic [LANES-1:0]  bw_n;           // lane enables
	logic [1:0]        nw_n;           // nibble enables
	logic              q_oe;           // data driven
	logic              echo_p, echo_n; // echo clocks
	int                n_fail = 0;     // mismatches
	int                checks_done = 0; // comparisons
	int                cycles = 0;     // hang guard
	logic [17:0]       exp_mem [logic [WADDR_W-1:0]]; // expected array
	dbs_row_s rows [6] = '{
		'{1'b0, 1'b1, 1'b0, 18'h0, 18'h10, 8'h11, 8'hff},
		'{1'b0, 1'b1, 1'b0, 18'h0, 18'h20, 8'h22, 8'hff},
		'{1'b0, 1'b1, 1'b0, 18'h0, 18'h20, 8'h33, 8'h1b},
		'{1'b1, 1'b1, 1'b0, 18'h10, 18'h30, 8'h44, 8'hff},
		'{1'b1, 1'b0, 1'b0, 18'h20, 18'h0, 8'h0, 8'h0},
		'{1'b1, 1'b0, 1'b0, 18'h30, 18'h0, 8'h0, 8'h0}
	};

	always #5 clk = ~clk; // 100 MHz

	dbs_ctl_model ctl_i (.in_clk_p(kp), .in_clk_n(kn), .out_clk_p(cp),
		.out_clk_n(cn), .rd_sel_n(rdn), .wr_sel_n(wrn), .addr_in(addr),
		.d_in(d), .wr_n(bw_n), .nib_n(nw_n));
	dbs_sram dbs_sram_i (.clk(clk), .rst_n(rst_n), .in_clk_p(kp),
		.in_clk_n(kn), .out_clk_p(cp), .out_clk_n(cn), .rd_sel_n(rdn),
		.wr_sel_n(wrn), .addr_in(addr), .d_in(d), .byte_wr_n0(bw_n[0]),
		.byte_wr_n1(bw_n[1]), .byte_wr_n2(bw_n[2]), .byte_wr_n3(bw_n[3]),
		.nib_wr_n0(nw_n[0]), .nib_wr_n1(nw_n[1]), .q_out(q), .q_oe(q_oe),
		.echo_clk_p(echo_p), .echo_clk_n(echo_n));

	// compare and count
	task automatic check(input logic [DQ_W-1:0] seen,
		input logic [DQ_W-1:0] exp, input string what);
		checks_done++;
		if ($isunknown(seen) || $isunknown(exp) || seen !== exp) begin
			n_fail++;
			$display("FAIL %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	// counts, verdict, end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// four words on reference edges, then release
	task automatic rd_check(input logic [ADDR_W-1:0] a);
		@(negedge kp);
		@(posedge kp);
		for (int i = 0; i < 5; i++) begin
			if (i[0]) @(posedge kp);
			else @(negedge kp);
			#60;
			if (i < 4) begin // words base+0..3
				check(q, DQ_W'(exp_mem[{a, 2'(i)}]), "read word");
				check(DQ_W'(q_oe), 36'h1, "q driven");
			end else begin // no further launch
				check(DQ_W'(q_oe), 36'h0, "q released");
			end
			check(DQ_W'(echo_p), DQ_W'(i[0]), "echo aligned");
		end
	endtask
	// idle link: outputs off, echo clocks keep running
	task automatic idle_check();
		repeat (2) begin
			@(posedge kp);
			#60;
			check(DQ_W'(echo_p), 36'h1, "echo high");
			check(DQ_W'(q_oe), 36'h0, "idle q off");
			@(negedge kp);
			#60;
			check(DQ_W'(echo_n), 36'h1, "echo low");
		end
	endtask
	// update expectation, then drive a slot and watch the read side
	task automatic run(input dbs_row_s r);
		logic [4*DQ_W-1:0]  dat;
		logic [DQ_W-1:0]    b;
		logic [17:0]        w;
		logic [WADDR_W-1:0] k;
		for (int i = 0; i < 4; i++) begin // beat i: {~a, a ^ pattern}
			b = {~r.aw, r.aw ^ {r.pat, 8'h00, 2'(i)}};
			dat[i*DQ_W +: DQ_W] = b;
			k = {r.aw, 2'(i)};
			w = exp_mem.exists(k) ? exp_mem[k] : 'x;
			if (r.en[2*i]) w[8:0] = b[8:0];
			if (r.en[2*i+1]) w[17:9] = b[17:9];
			if (r.wr) exp_mem[k] = w;
		end
		fork
			ctl_i.slot(r.rd, r.wr, r.dup, r.ar, r.aw, dat, r.en);
			if (r.rd) rd_check(r.ar);
		join
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			final_report();
		end
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		check(DQ_W'(q_oe), 36'h0, "oe in reset");
		check(q, 36'h0, "q in reset");
		#1 rst_n = 1'b1;
		idle_check();
		foreach (rows[i]) run(rows[i]);
		// repeated read strobe must not add a burst
		run('{1'b1, 1'b0, 1'b1, 18'h10, 18'h0, 8'h0, 8'h0});
		// repeated write strobe keeps the first burst intact
		run('{1'b0, 1'b1, 1'b1, 18'h0, 18'h40, 8'h55, 8'hff});
		run('{1'b1, 1'b0, 1'b0, 18'h40, 18'h0, 8'h0, 8'h0});
		// clocks parked low: outputs hold still, memory survives
		fork
			ctl_i.halt(4);
			begin
				@(negedge kp);
				#300;
				check(DQ_W'({echo_p, echo_n, q_oe}), 36'h0, "parked");
			end
		join
		run('{1'b1, 1'b0, 1'b0, 18'h20, 18'h0, 8'h0, 8'h0});
		// output clocks tied high: data and echo follow the input clocks
		ctl_i.kmode = 1'b1;
		idle_check();
		run('{1'b0, 1'b1, 1'b0, 18'h0, 18'h3ffff, 8'h66, 8'hff});
		run('{1'b1, 1'b1, 1'b0, 18'h3ffff, 18'h40, 8'h77, 8'he4});
		run('{1'b1, 1'b0, 1'b0, 18'h40, 18'h0, 8'h0, 8'h0});
		final_report();
	end
endmodule
